// ===== common/ccar_pkg.sv
// Package of register map, field positions, reset values and timing for the codec control block.
package ccar_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_MODE = 12'h000; // Mode register.
    localparam logic [11:0] ADDR_CLOCKF = 12'h00c; // Clock multiplier register.
    localparam logic [11:0] ADDR_VOL = 12'h02c; // Output attenuation.
    localparam logic [11:0] ADDR_HDAT0 = 12'h020; // Header word 0, buffer pop port.
    localparam logic [11:0] ADDR_HDAT1 = 12'h024; // Header word 1, fill count.
    localparam logic [11:0] ADDR_AIADDR = 12'h028; // Application start address.
    localparam logic [11:0] ADDR_AICTRL0 = 12'h030; // Application control word 0.
    localparam logic [11:0] ADDR_AICTRL1 = 12'h034; // Application control word 1.
    localparam logic [11:0] ADDR_AICTRL2 = 12'h038; // Application control word 2.
    localparam logic [11:0] ADDR_AICTRL3 = 12'h03c; // Application control word 3.
    localparam logic [11:0] ADDR_STATUS = 12'h040; // Block status.
    localparam logic [11:0] ADDR_SAMPLE = 12'h044; // Sample port address, not decoded; accesses return a slave error.

    // ------------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------------
    localparam int MODE_SOFT_RESET = 2; // Software reset bit.
    localparam int MODE_ABORT_FILE = 3; // Abort file bit.
    localparam int MODE_RECORD = 12; // Record enable bit.
    localparam int MODE_HIGHPASS = 13; // Record high-pass bit.
    localparam int MODE_LINE_IN = 14; // Line input select bit.
    localparam int MODE_CLK_RANGE = 15; // Clock range bit.
    localparam logic [15:0] MODE_RESET_VAL = 16'h0800; // Mode after hardware reset.

    // ------------------------------------------------------------------
    // Values and counts
    // ------------------------------------------------------------------
    localparam logic [15:0] VOL_FULL = 16'h0000; // Full volume.
    localparam logic [15:0] VOL_SILENT = 16'hfefe; // Total silence.
    localparam logic [15:0] VOL_POWERDOWN = 16'hffff; // Analog power-down code.
    localparam logic [15:0] CLOCKF_RESET_VAL = 16'h0000; // Multiplier 1.0.
    localparam logic [2:0] MULT_MAX = 3'h7; // Multiplier 4.5 as (2+7)/2.
    localparam logic [15:0] DIV_MIN = 16'h0004; // Lowest valid divider.
    localparam logic [15:0] DIV_DEFAULT = 16'h000c; // Divider used for zero.
    localparam logic [15:0] GAIN_UNITY = 16'h0400; // Unity linear gain.
    localparam logic [15:0] AGC_MAX_FULL = 16'hffff; // Full AGC range.
    localparam int STARTUP_CYCLES = 20000; // Data-request hold low cycles.
    localparam int SOFT_RESET_NS = 2000; // Least soft reset settling time.
    localparam int CLK_PERIOD_NS = 25; // Clock period.
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Rounded up.
    localparam int BUF_DEPTH = 1024; // Record buffer words.
    localparam int BLOCK_WORDS = 128; // Words per encoded block.
    localparam int ABORT_CYCLES = 64; // Cycles the abort takes to finish.

    // Pair of attenuation bytes.
    typedef struct packed {
        logic [7:0] left;
        logic [7:0] right;
    } ccar_atten_type;

endpackage : ccar_pkg

// ===== design/ccar_top.sv
// Control logic of the codec: registers on APB, resets, data request and record buffer.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module ccar_top
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [15:0] sample_word,
    output logic data_request,
    output logic analog_powerdown,
    output logic clock_halved,
    output logic [2:0] pll_mult,
    output ccar_pkg::ccar_atten_type atten,
    output logic recording,
    output logic record_highpass,
    output logic line_input_select,
    output logic [15:0] record_gain,
    output logic [15:0] agc_limit,
    output logic [15:0] rate_divider
);
    import ccar_pkg::*;

    // ------------------------------------------------------------------
    // Reset sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_BOOT = 3'b001,
        ST_SETTLE = 3'b010,
        ST_RUN = 3'b100
    } ccar_state_type;

    ccar_state_type state_reg; // Sequencer state.
    logic [15:0] mode_reg; // Mode register.
    logic [15:0] clockf_reg; // Clock multiplier register.
    logic [15:0] vol_reg; // Output attenuation register.
    logic [15:0] aiaddr_reg; // Application start address.
    logic [15:0] aictrl_reg [4]; // Application control words.
    logic [15:0] hdat1_reg; // Header word 1 when not recording.
    logic [14:0] wait_reg; // Startup counter.
    logic [6:0] abort_cnt_reg; // Abort progress counter.
    logic [15:0] buf_mem [BUF_DEPTH]; // Record buffer storage.
    logic [9:0] wr_ptr_reg; // Buffer write pointer.
    logic [9:0] rd_ptr_reg; // Buffer read pointer.
    logic [10:0] count_reg; // Buffer fill count.
    logic [6:0] blk_word_reg; // Word index inside the current block.
    logic overflow_reg; // Sticky overflow flag.
    logic [15:0] rd_word; // Word at the read pointer.

    // Decoded APB strobes; the slave answers in the access phase with no wait.
    logic wr_en;
    logic rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    // True when an access addresses the given register.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction : hit
    // Merges the low two byte lanes of a write into a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16
    logic soft_go;
    assign soft_go = wr_en && hit(paddr, ADDR_MODE) && pstrb[0] && pwdata[MODE_SOFT_RESET];
    logic pop;
    assign pop = rd_en && hit(paddr, ADDR_HDAT0) && mode_reg[MODE_RECORD] && (count_reg != 11'h000);
    logic push;
    assign push = sample_valid && mode_reg[MODE_RECORD] && (state_reg == ST_RUN);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Hardware reset sets everything; a soft reset leaves the volume alone.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_reg <= MODE_RESET_VAL;
            clockf_reg <= CLOCKF_RESET_VAL;
            vol_reg <= VOL_FULL;
            aiaddr_reg <= 16'h0000;
            for (int i = 0; i < 4; i++)
            begin
                aictrl_reg[i] <= 16'h0000;
            end
        end
        else
        begin
            if (wr_en && hit(paddr, ADDR_MODE))
            begin
                mode_reg <= merge16(mode_reg, pwdata, pstrb);
            end
            else if (abort_cnt_reg == 7'h01)
            begin
                // The abort finishes by clearing its own bit.
                mode_reg[MODE_ABORT_FILE] <= 1'b0;
            end
            else if (state_reg == ST_SETTLE && wait_reg == 15'h0000)
            begin
                // The reset bit clears itself once the startup wait ends.
                mode_reg[MODE_SOFT_RESET] <= 1'b0;
            end
            if (wr_en && hit(paddr, ADDR_CLOCKF))
            begin
                clockf_reg <= merge16(clockf_reg, pwdata, pstrb);
            end
            if (wr_en && hit(paddr, ADDR_VOL))
            begin
                vol_reg <= merge16(vol_reg, pwdata, pstrb);
            end
            if (wr_en && hit(paddr, ADDR_AIADDR))
            begin
                aiaddr_reg <= merge16(aiaddr_reg, pwdata, pstrb);
            end
            for (int i = 0; i < 4; i++)
            begin
                if (wr_en && paddr == ADDR_AICTRL0 + 12'(4 * i))
                begin
                    aictrl_reg[i] <= merge16(aictrl_reg[i], pwdata, pstrb);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Reset sequencer and data request
    // ------------------------------------------------------------------
    // Counts the startup wait after either reset before raising the request.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ST_BOOT;
            wait_reg <= 15'h0000;
        end
        else
        begin
            case (state_reg)
                ST_BOOT:
                begin
                    wait_reg <= 15'(STARTUP_CYCLES - 1);
                    state_reg <= ST_SETTLE;
                end
                ST_SETTLE:
                begin
                    if (wait_reg != 15'h0000)
                    begin
                        wait_reg <= wait_reg - 15'h0001;
                    end
                    else
                    begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (soft_go)
                    begin
                        // A soft reset holds the request low for the full wait.
                        wait_reg <= 15'(STARTUP_CYCLES - 1);
                        state_reg <= ST_SETTLE;
                    end
                end
                default:
                begin
                    state_reg <= ST_BOOT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Abort handling
    // ------------------------------------------------------------------
    // The abort takes a fixed time and then clears the abort bit and header word 1.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            abort_cnt_reg <= 7'h00;
            hdat1_reg <= 16'h0000;
        end
        else if (abort_cnt_reg != 7'h00)
        begin
            abort_cnt_reg <= abort_cnt_reg - 7'h01;
            if (abort_cnt_reg == 7'h01)
            begin
                hdat1_reg <= 16'h0000;
            end
        end
        else if (wr_en && hit(paddr, ADDR_MODE) && pstrb[0] && pwdata[MODE_ABORT_FILE])
        begin
            abort_cnt_reg <= 7'(ABORT_CYCLES);
        end
    end

    // ------------------------------------------------------------------
    // Record buffer
    // ------------------------------------------------------------------
    // Byte 3 of each block is forced to zero as the word is stored.
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            buf_mem[wr_ptr_reg] <= (blk_word_reg == 7'h01) ? {sample_word[15:8], 8'h00} : sample_word;
        end
    end
    assign rd_word = buf_mem[rd_ptr_reg];
    // Pointers and count; a push into a full buffer with no pop in the same cycle empties it instead.
    always_ff @(posedge clk)
    begin
        if (rst || soft_go)
        begin
            wr_ptr_reg <= 10'h000;
            rd_ptr_reg <= 10'h000;
            count_reg <= 11'h000;
            blk_word_reg <= 7'h00;
            overflow_reg <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                blk_word_reg <= blk_word_reg + 7'h01;
            end
            if (push && count_reg == 11'(BUF_DEPTH) && !pop)
            begin
                // Host was too slow: drop everything and restart empty.
                wr_ptr_reg <= 10'h000;
                rd_ptr_reg <= 10'h000;
                count_reg <= 11'h000;
                overflow_reg <= 1'b1;
            end
            else
            begin
                if (push)
                begin
                    wr_ptr_reg <= wr_ptr_reg + 10'h001;
                end
                if (pop)
                begin
                    rd_ptr_reg <= rd_ptr_reg + 10'h001;
                end
                count_reg <= count_reg + {10'h000, push} - {10'h000, pop};
                if (rd_en && hit(paddr, ADDR_STATUS))
                begin
                    overflow_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // APB read data and outputs
    // ------------------------------------------------------------------
    // Read data is registered in the setup cycle so it stands during access.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                case (paddr)
                    ADDR_MODE: prdata <= {16'h0000, mode_reg};
                    ADDR_CLOCKF: prdata <= {16'h0000, clockf_reg};
                    ADDR_VOL: prdata <= {16'h0000, vol_reg};
                    ADDR_AIADDR: prdata <= {16'h0000, aiaddr_reg};
                    ADDR_AICTRL0: prdata <= {16'h0000, aictrl_reg[0]};
                    ADDR_AICTRL1: prdata <= {16'h0000, aictrl_reg[1]};
                    ADDR_AICTRL2: prdata <= {16'h0000, aictrl_reg[2]};
                    ADDR_AICTRL3: prdata <= {16'h0000, aictrl_reg[3]};
                    ADDR_HDAT0: prdata <= {16'h0000, mode_reg[MODE_RECORD] ? rd_word : 16'h0000};
                    ADDR_HDAT1: prdata <= {16'h0000, mode_reg[MODE_RECORD] ? {5'h00, count_reg} : hdat1_reg};
                    ADDR_STATUS: prdata <= {28'h0000000, overflow_reg, state_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
                pslverr <= !(paddr inside {ADDR_MODE, ADDR_CLOCKF, ADDR_VOL, ADDR_AIADDR, ADDR_AICTRL0,
                    ADDR_AICTRL1, ADDR_AICTRL2, ADDR_AICTRL3, ADDR_HDAT0, ADDR_HDAT1, ADDR_STATUS});
            end
        end
    end
    // Functional outputs, each taken from a flop.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            data_request <= 1'b0;
            analog_powerdown <= 1'b1;
            clock_halved <= 1'b0;
            pll_mult <= 3'h0;
            atten <= '0;
            recording <= 1'b0;
            record_highpass <= 1'b0;
            line_input_select <= 1'b0;
            record_gain <= GAIN_UNITY;
            agc_limit <= AGC_MAX_FULL;
            rate_divider <= DIV_DEFAULT;
        end
        else
        begin
            data_request <= (state_reg == ST_RUN) && !soft_go;
            analog_powerdown <= (vol_reg == VOL_POWERDOWN);
            atten <= (vol_reg == VOL_POWERDOWN) ? ccar_atten_type'(VOL_SILENT) : ccar_atten_type'(vol_reg);
            clock_halved <= mode_reg[MODE_CLK_RANGE];
            pll_mult <= (clockf_reg[15:13] > MULT_MAX) ? MULT_MAX : clockf_reg[15:13];
            recording <= mode_reg[MODE_RECORD] && (state_reg == ST_RUN);
            record_highpass <= mode_reg[MODE_RECORD] && mode_reg[MODE_HIGHPASS];
            line_input_select <= mode_reg[MODE_LINE_IN];
            record_gain <= aictrl_reg[1];
            agc_limit <= (aictrl_reg[2] == 16'h0000) ? AGC_MAX_FULL : aictrl_reg[2];
            // Zero picks the default divider; anything below the minimum is raised to it.
            rate_divider <= (aictrl_reg[0] == 16'h0000) ? DIV_DEFAULT :
                ((aictrl_reg[0] < DIV_MIN) ? DIV_MIN : aictrl_reg[0]);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_powerdown;
        @(posedge clk) disable iff (rst) (vol_reg == VOL_POWERDOWN) |=> analog_powerdown;
    endproperty
    a_powerdown: assert property (p_powerdown) else $error("powerdown not raised");
    property p_soft_drops_req;
        @(posedge clk) disable iff (rst) soft_go |=> !data_request [*8];
    endproperty
    a_soft_drops_req: assert property (p_soft_drops_req) else $error("request rose early");
    property p_boot_low;
        @(posedge clk) $fell(rst) |-> !data_request [*8];
    endproperty
    a_boot_low: assert property (p_boot_low) else $error("request high after reset");
    property p_div_zero;
        @(posedge clk) disable iff (rst) (aictrl_reg[0] == 16'h0000) [*2] |-> rate_divider == DIV_DEFAULT;
    endproperty
    a_div_zero: assert property (p_div_zero) else $error("divider zero not twelve");
    property p_agc_full;
        @(posedge clk) disable iff (rst) (aictrl_reg[2] == 16'h0000) [*2] |-> agc_limit == AGC_MAX_FULL;
    endproperty
    a_agc_full: assert property (p_agc_full) else $error("agc limit wrong");
    property p_overflow_empty;
        @(posedge clk) disable iff (rst) (push && !pop && count_reg == 11'(BUF_DEPTH) && !soft_go)
            |=> count_reg == 11'h000 && overflow_reg;
    endproperty
    a_overflow_empty: assert property (p_overflow_empty) else $error("overflow kept data");
    property p_count_max;
        @(posedge clk) disable iff (rst) count_reg <= 11'(BUF_DEPTH);
    endproperty
    a_count_max: assert property (p_count_max) else $error("count above depth");
    property p_abort_clears;
        @(posedge clk) disable iff (rst) (abort_cnt_reg == 7'h01 && !wr_en) |=> !mode_reg[MODE_ABORT_FILE];
    endproperty
    a_abort_clears: assert property (p_abort_clears) else $error("abort bit stuck");

    c_record: cover property (@(posedge clk) disable iff (rst) push ##1 pop);
    c_overflow: cover property (@(posedge clk) disable iff (rst) $rose(overflow_reg));
    c_soft: cover property (@(posedge clk) disable iff (rst) soft_go ##1 !data_request);

endmodule : ccar_top

// ===== verification/ccar_sample_src.sv
// Partner model: the encoder that feeds words to the record buffer.
`timescale 1ns/1ps
module ccar_sample_src
(
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [15:0] word_in,
    output logic sample_valid,
    output logic [15:0] sample_word
);
    // One word every other cycle; between words the bus shows the inverse of the last word,
    // so a design that samples off the strobe sees garbage rather than a lucky match.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sample_valid <= 1'b0;
            sample_word <= 16'h0000;
        end
        else
        begin
            sample_valid <= en & ~sample_valid;
            sample_word <= (en & ~sample_valid) ? word_in : ~sample_word;
        end
    end
endmodule : ccar_sample_src

// ===== verification/tb_top.sv
// Self-checking testbench of the codec control block with a queue model of the buffer.
`timescale 1ns/1ps
module tb_top;
    import ccar_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, en = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic [15:0] rnd = 16'h003c, sample_word, record_gain, agc_limit, rate_divider, gv;
    logic pready, pslverr, sample_valid, data_request, analog_powerdown, clock_halved;
    logic recording, record_highpass, line_input_select;
    logic [2:0] pll_mult;
    ccar_atten_type atten;
    int fail_count = 0, total_checks = 0, n, pushes = 0;
    logic [15:0] q[$]; // Words the model expects in the buffer.
    logic [15:0] tv[4] = '{16'h0407, VOL_SILENT, VOL_POWERDOWN, VOL_FULL};
    logic [15:0] dv[3] = '{16'h0000, 16'h0002, 16'h0012};
    logic [15:0] de[3] = '{DIV_DEFAULT, DIV_MIN, 16'h0012};

    ccar_top i_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample_word(sample_word), .data_request(data_request),
        .analog_powerdown(analog_powerdown), .clock_halved(clock_halved), .pll_mult(pll_mult), .atten(atten),
        .recording(recording), .record_highpass(record_highpass), .line_input_select(line_input_select),
        .record_gain(record_gain), .agc_limit(agc_limit), .rate_divider(rate_divider));
    ccar_sample_src i_src (.clk(clk), .rst(rst), .en(en), .word_in(rnd), .sample_valid(sample_valid),
        .sample_word(sample_word));

    // ------------------------------------------------------------------
    // Clock, random source and buffer model
    // ------------------------------------------------------------------
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    // A push into a full buffer empties it; the second word of each block loses its low byte.
    always @(posedge clk)
    begin
        rnd <= lfsr(rnd);
        if (sample_valid === 1'b1 && recording === 1'b1 && data_request === 1'b1)
        begin
            if (q.size() == BUF_DEPTH)
                q.delete();
            else
                q.push_back((pushes % BLOCK_WORDS == 1) ? {sample_word[15:8], 8'h00} : sample_word);
            pushes++;
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            fail_count++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Bounded wait for the data request to rise; n holds the cycles waited.
    task automatic wait_req(input int lo);
        n = 0;
        while (data_request !== 1'b1 && n < 21000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 21000)
        begin
            fail_count++;
            wrap_up();
        end
        chk("request_delay_ok", 1, n >= lo);
    endtask : wait_req

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        chk("request_in_reset", 0, data_request);
        chk("powerdown_in_reset", 1, analog_powerdown);
        rst <= 1'b0;
        apb(ADDR_MODE, 1, 32'h00008800);
        apb(ADDR_MODE, 0, 0);
        chk("mode", 32'h00008800, rd);
        chk("clock_halved", 1, clock_halved);
        wait_req(STARTUP_CYCLES - 10);
        apb(ADDR_VOL, 0, 0);
        chk("vol_reset", VOL_FULL, rd);
        apb(ADDR_CLOCKF, 0, 0);
        chk("clockf_reset", CLOCKF_RESET_VAL, rd);
        // Attenuation codes, including silence and power-down.
        foreach (tv[i])
        begin
            apb(ADDR_VOL, 1, {16'h0000, tv[i]});
            apb(ADDR_VOL, 0, 0);
            chk("vol", tv[i], rd);
            chk("atten", (tv[i] == VOL_POWERDOWN) ? VOL_SILENT : tv[i], atten);
            chk("powerdown", tv[i] == VOL_POWERDOWN, analog_powerdown);
        end
        apb(ADDR_CLOCKF, 1, {16'h0000, MULT_MAX, 13'h0000});
        apb(ADDR_CLOCKF, 0, 0);
        chk("clockf", 32'h0000e000, rd);
        chk("pll_max", MULT_MAX, pll_mult);
        apb(ADDR_CLOCKF, 1, 32'h00006000);
        apb(ADDR_AIADDR, 0, 0);
        chk("pll_mult", 3'h3, pll_mult);
        foreach (dv[i])
        begin
            apb(ADDR_AICTRL0, 1, dv[i]);
            apb(ADDR_AICTRL0, 0, 0);
            chk("divider", de[i], rate_divider);
        end
        // One random word, kept aside, goes to the gain, the AGC cap and the start address.
        gv = rnd;
        apb(ADDR_AICTRL2, 1, {16'h0000, gv});
        apb(ADDR_AICTRL1, 1, {16'h0000, gv});
        apb(ADDR_AIADDR, 1, {16'h0000, gv});
        apb(ADDR_AIADDR, 0, 0);
        chk("aiaddr", gv, rd);
        chk("gain", gv, record_gain);
        chk("agc_cap", (gv == 16'h0000) ? AGC_MAX_FULL : gv, agc_limit);
        apb(ADDR_AICTRL2, 1, 0);
        apb(ADDR_AICTRL1, 1, 0);
        apb(12'h100, 0, 0);
        chk("unmapped_err", 1, err);
        chk("unmapped_data", 0, rd);
        chk("agc_limit", AGC_MAX_FULL, agc_limit);
        chk("gain_agc", 0, record_gain);
        apb(ADDR_VOL, 1, 32'h00002424);
        // Idle wait of 2048 cycles with no stream, then the soft reset with the clock range bit kept.
        repeat (2048) @(posedge clk);
        apb(ADDR_MODE, 1, 32'h00008804);
        repeat (SOFT_RESET_CYCLES) @(posedge clk);
        chk("request_soft", 0, data_request);
        wait_req(STARTUP_CYCLES - SOFT_RESET_CYCLES - 2);
        apb(ADDR_VOL, 0, 0);
        chk("vol_kept", 32'h00002424, rd);
        // Recording: soft reset with record, high-pass and line input together.
        q.delete();
        pushes = 0;
        apb(ADDR_MODE, 1, 32'h0000f004);
        repeat (SOFT_RESET_CYCLES) @(posedge clk);
        wait_req(STARTUP_CYCLES - SOFT_RESET_CYCLES - 2);
        chk("record_mode", 3'h7, {recording, record_highpass, line_input_select});
        en <= 1'b1;
        repeat (400) @(posedge clk);
        en <= 1'b0;
        apb(ADDR_HDAT1, 0, 0);
        chk("fill", q.size(), rd);
        for (int i = 0; i < BLOCK_WORDS; i++)
        begin
            apb(ADDR_HDAT0, 0, 0);
            chk("pop", q.pop_front(), rd);
        end
        en <= 1'b1;
        repeat (2400) @(posedge clk);
        en <= 1'b0;
        apb(ADDR_STATUS, 0, 0);
        chk("overflow", 1, rd[3]);
        apb(ADDR_STATUS, 0, 0);
        chk("overflow_clr", 0, rd[3]);
        apb(ADDR_HDAT1, 0, 0);
        chk("fill_after", q.size(), rd);
        // Abort with recording off, so header word 1 shows its own register.
        apb(ADDR_MODE, 1, 32'h00008008);
        apb(ADDR_MODE, 0, 0);
        chk("abort_set", 1, rd[MODE_ABORT_FILE]);
        repeat (ABORT_CYCLES + 4) @(posedge clk);
        apb(ADDR_MODE, 0, 0);
        chk("abort_bit", 0, rd[MODE_ABORT_FILE]);
        apb(ADDR_HDAT1, 0, 0);
        chk("abort_hdat1", 0, rd);
        // Hardware reset in mid-run returns every register to its initial value.
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(ADDR_VOL, 0, 0);
        chk("vol_hw", VOL_FULL, rd);
        apb(ADDR_MODE, 0, 0);
        chk("mode_hw", MODE_RESET_VAL, rd);
        wrap_up();
    end

    // Watchdog against a hang anywhere in the sequence.
    initial
    begin
        repeat (100000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
endmodule : tb_top
